// file: rtl/rst_seq_pkg.sv
// Shared constants and types of the reset time-out sequencer.
package rst_seq_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned POWER_UP_DELAY_MS = 72;
    localparam int unsigned POWER_UP_CYCLES = POWER_UP_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned POWER_UP_DELAY_TIMER_WIDTH = 20;
    localparam int unsigned OSC_SETTLE_CYCLES = 1024;
    localparam int unsigned OST_WIDTH = 11;

    localparam logic [2:0] ADDR_POWER_STATUS = 3'h0;
    localparam logic [2:0] ADDR_CPU_STATUS = 3'h1;
    localparam logic [2:0] ADDR_OPTION_CFG = 3'h2;
    localparam logic [2:0] ADDR_PORT_DIR = 3'h3;
    localparam logic [2:0] ADDR_SEQ_INFO = 3'h4;

    localparam int unsigned BROWNOUT_BIT = 0;
    localparam int unsigned POWER_ON_BIT = 1;
    localparam int unsigned EXPIRY_BIT = 4;
    localparam int unsigned SLEEP_BIT = 3;

    localparam logic [7:0] POWER_STATUS_RESET = 8'h00;
    localparam logic [7:0] CPU_STATUS_RESET = 8'h18;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [12:0] PC_RESET_VECTOR = 13'h0000;
    localparam logic [12:0] PC_IRQ_VECTOR = 13'h0004;

    typedef enum logic [1:0]
    {
        SLOW_CRYSTAL_MODE = 2'b00,
        STD_CRYSTAL_MODE = 2'b01,
        FAST_CRYSTAL_MODE = 2'b10,
        RESISTOR_CAPACITOR_MODE = 2'b11
    } osc_mode_e;

    typedef enum logic [1:0]
    {
        SEQ_RUN = 2'b00,
        SEQ_POWER_UP = 2'b01,
        SEQ_OSC_SETTLE = 2'b10,
        SEQ_HOLD = 2'b11
    } seq_state_e;

    typedef enum logic [2:0]
    {
        CAUSE_POWER_ON = 3'b000,
        CAUSE_BROWNOUT = 3'b001,
        CAUSE_EXT_RUN = 3'b010,
        CAUSE_EXT_SLEEP = 3'b011,
        CAUSE_WDT_RESET = 3'b100,
        CAUSE_WDT_WAKE = 3'b101,
        CAUSE_IRQ_WAKE = 3'b110
    } cause_e;

    // Status register image: value is loaded only where the mask bit is set.
    typedef struct packed
    {
        logic [7:0] value;
        logic [7:0] mask;
    } status_load_s;

    localparam status_load_s LOAD_POWER_ON = '{value: 8'h18, mask: 8'hF8};
    localparam status_load_s LOAD_BROWNOUT = '{value: 8'h18, mask: 8'hF8};
    localparam status_load_s LOAD_EXT_RUN = '{value: 8'h00, mask: 8'hE0};
    localparam status_load_s LOAD_EXT_SLEEP = '{value: 8'h10, mask: 8'hF8};
    localparam status_load_s LOAD_WDT_RESET = '{value: 8'h08, mask: 8'hF8};
    localparam status_load_s LOAD_WDT_WAKE = '{value: 8'h00, mask: 8'h18};
    localparam status_load_s LOAD_IRQ_WAKE = '{value: 8'h10, mask: 8'h18};

    typedef struct packed
    {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

// file: rtl/tick_counter.sv
// Terminal-count counter used by both time-out timers.
`timescale 1ns/1ps
`default_nettype none

module tick_counter #(
    parameter int unsigned WIDTH = 11,
    parameter logic [WIDTH-1:0] TERMINAL = '1
) (
    input wire logic core_clk_i, // Block clock.
    input wire logic rst_i,      // Synchronous reset, active high.
    input wire logic clear_i,    // Hold count at zero.
    input wire logic tick_i,     // One-cycle count enable.
    output logic done_o          // Terminal count reached.
);

    logic [WIDTH-1:0] count;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || clear_i)
        begin
            count <= '0;
            done_o <= 1'b0;
        end
        else if (tick_i && !done_o)
        begin
            count <= count + 1'b1;
            done_o <= (count == TERMINAL - 1'b1);
        end
    end

endmodule // tick_counter

`default_nettype wire

// file: rtl/reset_timeout_sequencer.sv
// Reset time-out sequencer with reset-cause flags and register reloads.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module reset_timeout_sequencer #(
    parameter logic [19:0] POWER_UP_CYCLES = 20'(rst_seq_pkg::POWER_UP_CYCLES)
) (
    input wire logic core_clk_i,                // 10 MHz internal timebase.
    input wire logic rst_i,                     // Synchronous reset, active high.
    input wire logic power_on_event_i,          // Supply rise detected, one-cycle pulse.
    input wire logic brownout_event_i,          // Supply recovered after brown-out, pulse.
    input wire logic ext_reset_n_i,             // External reset pin level, active low.
    input wire logic watchdog_timeout_i,        // Watchdog expiry, one-cycle pulse.
    input wire logic wake_irq_i,                // Enabled interrupt request level.
    input wire logic sleeping_i,                // Core is in sleep.
    input wire logic global_irq_enable_i,       // Global interrupt enable level.
    input wire logic osc_i,                     // Oscillator input level.
    input wire logic [1:0] osc_mode_i,          // Oscillator configuration.
    input wire logic power_up_delay_enable_n_i, // Power-up delay enable, active low.
    input wire logic brownout_enable_i,         // Brown-out reset enabled.
    input wire logic [12:0] pc_i,               // Current program counter.
    input wire rst_seq_pkg::reg_req_s req_i,    // Register request.
    output logic [7:0] rdata_o,                 // Read data, cycle after the read.
    output logic core_reset_o,                  // Internal reset to the core.
    output logic pc_load_o,                     // Program counter load pulse.
    output logic [12:0] pc_value_o,             // Program counter load value.
    output logic [7:0] cpu_status_o,            // Status register image.
    output logic [7:0] option_cfg_o,            // Option configuration register.
    output logic [7:0] port_dir_o               // Port direction register.
);

    rst_seq_pkg::seq_state_e state;
    rst_seq_pkg::cause_e cause;
    rst_seq_pkg::status_load_s load_sel;
    logic [7:0] power_status;
    logic crystal_mode;
    logic delay_on;
    logic osc_prev;
    logic osc_edge;
    logic power_up_done;
    logic settle_done;
    logic release_now;
    logic is_wake;
    logic supply_restart;
    logic [12:0] next_pc;

    assign crystal_mode = (osc_mode_i != rst_seq_pkg::RESISTOR_CAPACITOR_MODE);
    assign delay_on = !power_up_delay_enable_n_i || brownout_enable_i;
    assign osc_edge = osc_i && !osc_prev;
    // A supply event seen mid-count must start the timers again from zero.
    assign supply_restart = power_on_event_i || (brownout_event_i && brownout_enable_i);
    assign release_now = (state == rst_seq_pkg::SEQ_HOLD) && ext_reset_n_i;
    assign is_wake = (cause == rst_seq_pkg::CAUSE_WDT_WAKE)
        || (cause == rst_seq_pkg::CAUSE_IRQ_WAKE);

    // The core clock serves as the internal timebase so the delay is free of the oscillator.
    tick_counter #(
        .WIDTH(20),
        .TERMINAL(POWER_UP_CYCLES)
    ) u_power_up_delay_timer (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clear_i((state != rst_seq_pkg::SEQ_POWER_UP) || supply_restart),
        .tick_i(1'b1),
        .done_o(power_up_done)
    );

    tick_counter #(
        .WIDTH(11),
        .TERMINAL(11'(rst_seq_pkg::OSC_SETTLE_CYCLES))
    ) u_oscillator_settle_counter (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clear_i((state != rst_seq_pkg::SEQ_OSC_SETTLE) || supply_restart),
        .tick_i(osc_edge),
        .done_o(settle_done)
    );

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            osc_prev <= 1'b0;
        end
        else
        begin
            osc_prev <= osc_i;
        end
    end

    // Sequencer: supply events restart from any state; others only while running.
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            state <= rst_seq_pkg::SEQ_RUN;
            cause <= rst_seq_pkg::CAUSE_POWER_ON;
        end
        else if (power_on_event_i)
        begin
            cause <= rst_seq_pkg::CAUSE_POWER_ON;
            if (delay_on)
                state <= rst_seq_pkg::SEQ_POWER_UP;
            else if (crystal_mode)
                state <= rst_seq_pkg::SEQ_OSC_SETTLE;
            else
                state <= rst_seq_pkg::SEQ_HOLD;
        end
        else if (brownout_event_i && brownout_enable_i)
        begin
            cause <= rst_seq_pkg::CAUSE_BROWNOUT;
            state <= rst_seq_pkg::SEQ_POWER_UP;
        end
        else
        begin
            case (state)
                rst_seq_pkg::SEQ_RUN:
                begin
                    if (!ext_reset_n_i)
                    begin
                        cause <= sleeping_i ? rst_seq_pkg::CAUSE_EXT_SLEEP
                                            : rst_seq_pkg::CAUSE_EXT_RUN;
                        state <= rst_seq_pkg::SEQ_HOLD;
                    end
                    else if (watchdog_timeout_i && !sleeping_i)
                    begin
                        // Internal only: nothing here drives the external pin.
                        cause <= rst_seq_pkg::CAUSE_WDT_RESET;
                        state <= rst_seq_pkg::SEQ_HOLD;
                    end
                    else if (sleeping_i && (watchdog_timeout_i || wake_irq_i))
                    begin
                        cause <= watchdog_timeout_i ? rst_seq_pkg::CAUSE_WDT_WAKE
                                                    : rst_seq_pkg::CAUSE_IRQ_WAKE;
                        state <= crystal_mode ? rst_seq_pkg::SEQ_OSC_SETTLE
                                              : rst_seq_pkg::SEQ_HOLD;
                    end
                end
                rst_seq_pkg::SEQ_POWER_UP:
                begin
                    if (power_up_done)
                        state <= crystal_mode ? rst_seq_pkg::SEQ_OSC_SETTLE
                                              : rst_seq_pkg::SEQ_HOLD;
                end
                rst_seq_pkg::SEQ_OSC_SETTLE:
                begin
                    if (settle_done)
                        state <= rst_seq_pkg::SEQ_HOLD;
                end
                rst_seq_pkg::SEQ_HOLD:
                begin
                    if (ext_reset_n_i)
                        state <= rst_seq_pkg::SEQ_RUN;
                end
                default:
                begin
                    state <= rst_seq_pkg::SEQ_RUN;
                end
            endcase
        end
    end

    // Reset stays on through delay, settle and hold, so in crystal modes release after a supply event or a wake follows the settle count.
    assign core_reset_o = (state != rst_seq_pkg::SEQ_RUN);

    always_comb
    begin
        case (cause)
            rst_seq_pkg::CAUSE_POWER_ON: load_sel = rst_seq_pkg::LOAD_POWER_ON;
            rst_seq_pkg::CAUSE_BROWNOUT: load_sel = rst_seq_pkg::LOAD_BROWNOUT;
            rst_seq_pkg::CAUSE_EXT_RUN: load_sel = rst_seq_pkg::LOAD_EXT_RUN;
            rst_seq_pkg::CAUSE_EXT_SLEEP: load_sel = rst_seq_pkg::LOAD_EXT_SLEEP;
            rst_seq_pkg::CAUSE_WDT_RESET: load_sel = rst_seq_pkg::LOAD_WDT_RESET;
            rst_seq_pkg::CAUSE_WDT_WAKE: load_sel = rst_seq_pkg::LOAD_WDT_WAKE;
            rst_seq_pkg::CAUSE_IRQ_WAKE: load_sel = rst_seq_pkg::LOAD_IRQ_WAKE;
            default: load_sel = rst_seq_pkg::LOAD_POWER_ON;
        endcase
    end

    always_comb
    begin
        next_pc = rst_seq_pkg::PC_RESET_VECTOR;
        if (cause == rst_seq_pkg::CAUSE_WDT_WAKE)
            next_pc = pc_i + 13'h0001;
        else if (cause == rst_seq_pkg::CAUSE_IRQ_WAKE)
            next_pc = global_irq_enable_i ? rst_seq_pkg::PC_IRQ_VECTOR
                                          : pc_i + 13'h0001;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            pc_load_o <= 1'b0;
            pc_value_o <= rst_seq_pkg::PC_RESET_VECTOR;
        end
        else
        begin
            pc_load_o <= release_now;
            if (release_now)
                pc_value_o <= next_pc;
        end
    end

    // Hardware loads at release override a software write in the same cycle.
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            power_status <= rst_seq_pkg::POWER_STATUS_RESET;
        end
        else
        begin
            if (req_i.wr && req_i.addr == rst_seq_pkg::ADDR_POWER_STATUS)
                power_status[1:0] <= req_i.wdata[1:0];
            if (release_now && cause == rst_seq_pkg::CAUSE_POWER_ON)
                power_status[rst_seq_pkg::POWER_ON_BIT] <= 1'b0;
            // When brown-out reset is off no brown-out ever clears the flag, so it means nothing.
            if (release_now && cause == rst_seq_pkg::CAUSE_BROWNOUT)
                power_status[rst_seq_pkg::BROWNOUT_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            cpu_status_o <= rst_seq_pkg::CPU_STATUS_RESET;
        end
        else
        begin
            if (req_i.wr && req_i.addr == rst_seq_pkg::ADDR_CPU_STATUS)
                cpu_status_o <= req_i.wdata;
            if (release_now)
                cpu_status_o <= (cpu_status_o & ~load_sel.mask)
                    | (load_sel.value & load_sel.mask);
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            option_cfg_o <= rst_seq_pkg::ALL_ONES;
            port_dir_o <= rst_seq_pkg::ALL_ONES;
        end
        else
        begin
            if (req_i.wr && req_i.addr == rst_seq_pkg::ADDR_OPTION_CFG)
                option_cfg_o <= req_i.wdata;
            if (req_i.wr && req_i.addr == rst_seq_pkg::ADDR_PORT_DIR)
                port_dir_o <= req_i.wdata;
            if (release_now && !is_wake)
            begin
                option_cfg_o <= rst_seq_pkg::ALL_ONES;
                port_dir_o <= rst_seq_pkg::ALL_ONES;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (req_i.rd)
        begin
            case (req_i.addr)
                rst_seq_pkg::ADDR_POWER_STATUS: rdata_o <= {6'h00, power_status[1:0]};
                rst_seq_pkg::ADDR_CPU_STATUS: rdata_o <= cpu_status_o;
                rst_seq_pkg::ADDR_OPTION_CFG: rdata_o <= option_cfg_o;
                rst_seq_pkg::ADDR_PORT_DIR: rdata_o <= port_dir_o;
                rst_seq_pkg::ADDR_SEQ_INFO: rdata_o <= {2'h0, core_reset_o, cause, state};
                default: rdata_o <= 8'h00;
            endcase
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

endmodule // reset_timeout_sequencer

`default_nettype wire

// file: verification/reset_timeout_sequencer_props.sv
// Port-level checks of the reset time-out sequencer.
`timescale 1ns/1ps
`default_nettype none

module reset_timeout_sequencer_props #(
    parameter logic [19:0] POWER_UP_CYCLES = 20'h00014
) (
    input wire logic core_clk_i, // Clock.
    input wire logic rst_i, // Reset.
    input wire logic power_on_event_i, // Supply rise.
    input wire logic brownout_event_i, // Brown-out recovery.
    input wire logic ext_reset_n_i, // Reset pin.
    input wire logic watchdog_timeout_i, // Watchdog expiry.
    input wire logic sleeping_i, // Core asleep.
    input wire logic [1:0] osc_mode_i, // Oscillator mode.
    input wire logic power_up_delay_enable_n_i, // Delay enable.
    input wire logic brownout_enable_i, // Brown-out enable.
    input wire rst_seq_pkg::reg_req_s req_i, // Register request.
    input wire logic core_reset_o, // Core reset.
    input wire logic pc_load_o, // PC load pulse.
    input wire logic [7:0] cpu_status_o, // Status image.
    input wire logic [7:0] option_cfg_o, // Option register.
    input wire logic [7:0] port_dir_o // Port direction.
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    // Counts reset cycles since the last supply event, to bound the power-up delay from below.
    logic [21:0] hold_cnt;
    logic timed;
    logic supply_evt;
    assign supply_evt = power_on_event_i || (brownout_event_i && brownout_enable_i);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || supply_evt)
            hold_cnt <= '0;
        else if (core_reset_o)
            hold_cnt <= hold_cnt + 22'h1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            timed <= 1'b0;
        else if (supply_evt)
            timed <= !power_up_delay_enable_n_i || brownout_enable_i;
        else if (!core_reset_o)
            timed <= 1'b0;
    end

    property p_por_holds; power_on_event_i |=> core_reset_o; endproperty
    a_por_holds: assert property (p_por_holds) else $error("no reset after supply rise");
    property p_bor_holds; brownout_event_i && brownout_enable_i |=> core_reset_o [*8]; endproperty
    a_bor_holds: assert property (p_bor_holds) else $error("brown-out delay too short");
    property p_xtal_holds; power_on_event_i && osc_mode_i != 2'b11 |=> core_reset_o [*8]; endproperty
    a_xtal_holds: assert property (p_xtal_holds) else $error("settle count skipped");
    property p_delay_len; $fell(core_reset_o) && timed |-> hold_cnt >= {2'b00, POWER_UP_CYCLES};
    endproperty
    a_delay_len: assert property (p_delay_len) else $error("power-up delay too short");
    property p_ext_keeps; core_reset_o && !ext_reset_n_i |=> core_reset_o; endproperty
    a_ext_keeps: assert property (p_ext_keeps) else $error("released with pin low");
    property p_release_ext; $fell(core_reset_o) |-> $past(ext_reset_n_i); endproperty
    a_release_ext: assert property (p_release_ext) else $error("release without pin high");
    property p_pc_load; $fell(core_reset_o) |-> pc_load_o ##1 !pc_load_o; endproperty
    a_pc_load: assert property (p_pc_load) else $error("pc load pulse wrong");
    property p_wdt_reset;
        watchdog_timeout_i && !sleeping_i && !core_reset_o && ext_reset_n_i |=> core_reset_o;
    endproperty
    a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset missing");
    property p_opt_hold; $changed(option_cfg_o) || $changed(port_dir_o) |-> $past(req_i.wr) || pc_load_o;
    endproperty
    a_opt_hold: assert property (p_opt_hold) else $error("option changed by itself");
    property p_st_hold; $changed(cpu_status_o) |-> $past(req_i.wr) || pc_load_o; endproperty
    a_st_hold: assert property (p_st_hold) else $error("status changed by itself");
    property p_wake_bit; pc_load_o && option_cfg_o != 8'hFF |-> !cpu_status_o[3]; endproperty
    a_wake_bit: assert property (p_wake_bit) else $error("wake left sleep bit set");
endmodule // reset_timeout_sequencer_props

`default_nettype wire

// file: verification/supply_pin_model.sv
// Supply monitor, reset pin and oscillator around the sequencer.
`timescale 1ns/1ps
`default_nettype none

module supply_pin_model (
    input wire logic core_clk_i, // Clock.
    output logic power_on_o, // Supply rise pulse.
    output logic brownout_o, // Brown-out recovery pulse.
    output logic ext_reset_n_o, // Reset pin level.
    output logic osc_o // Oscillator level.
);
    // Half period in clocks; the fast-crystal timing case raises it to 2.
    int osc_half = 1;
    int osc_cnt = 0;

    initial
    begin
        power_on_o = 1'b0;
        brownout_o = 1'b0;
        ext_reset_n_o = 1'b1;
        osc_o = 1'b0;
    end

    always @(posedge core_clk_i)
    begin
        if (osc_cnt + 1 >= osc_half)
        begin
            osc_cnt <= 0;
            osc_o <= ~osc_o;
        end
        else
            osc_cnt <= osc_cnt + 1;
    end

    task supply_rise();
        @(posedge core_clk_i);
        power_on_o <= 1'b1;
        @(posedge core_clk_i);
        power_on_o <= 1'b0;
    endtask

    task brownout_recover();
        @(posedge core_clk_i);
        brownout_o <= 1'b1;
        @(posedge core_clk_i);
        brownout_o <= 1'b0;
    endtask

    task set_pin(input logic v);
        @(posedge core_clk_i);
        ext_reset_n_o <= v;
    endtask
endmodule // supply_pin_model

`default_nettype wire

// file: verification/reset_timeout_sequencer_tb_top.sv
// Self-checking testbench of the reset time-out sequencer.
`timescale 1ns/1ps
`default_nettype none

module reset_timeout_sequencer_tb_top;
    localparam logic [19:0] PUC = 20'h00014;
    logic clk;
    logic rst;
    logic wdt;
    logic irq;
    logic sleeping;
    logic global_irq_enable;
    logic [1:0] mode;
    logic dly_n;
    logic bor_en;
    rst_seq_pkg::reg_req_s req;
    wire logic por_w;
    wire logic bor_w;
    wire logic ext_n;
    wire logic osc;
    logic [7:0] rdata;
    logic core_reset;
    logic pc_load;
    logic [12:0] pc_value;
    logic [12:0] pc;
    logic [7:0] status;
    logic [7:0] opt;
    logic [7:0] pdir;
    int fail_count = 0;
    int n_tests = 0;

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    supply_pin_model i_model (.core_clk_i(clk), .power_on_o(por_w), .brownout_o(bor_w),
        .ext_reset_n_o(ext_n), .osc_o(osc));

    reset_timeout_sequencer #(.POWER_UP_CYCLES(PUC)) i_dut (.core_clk_i(clk), .rst_i(rst),
        .power_on_event_i(por_w), .brownout_event_i(bor_w), .ext_reset_n_i(ext_n),
        .watchdog_timeout_i(wdt), .wake_irq_i(irq), .sleeping_i(sleeping),
        .global_irq_enable_i(global_irq_enable), .osc_i(osc), .osc_mode_i(mode),
        .power_up_delay_enable_n_i(dly_n), .brownout_enable_i(bor_en), .pc_i(pc),
        .req_i(req), .rdata_o(rdata), .core_reset_o(core_reset), .pc_load_o(pc_load),
        .pc_value_o(pc_value), .cpu_status_o(status), .option_cfg_o(opt), .port_dir_o(pdir));

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi)
        begin
            fail_count++;
            $display("MISMATCH t=%0t cycles=%h range=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Counts cycles until the core leaves reset; a stuck reset ends the run.
    task automatic wait_rel(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (core_reset === 1'b1 && n < 8000);
        if (n >= 8000)
        begin
            fail_count++;
            conclude();
        end
    endtask

    task automatic t_regs();
        logic [7:0] d;
        logic [7:0] exp [4] = '{8'h00, 8'h18, 8'hFF, 8'hFF};
        for (int a = 0; a < 4; a++)
        begin
            rd(3'(a), d);
            chk(d, exp[a]);
        end
        wr(rst_seq_pkg::ADDR_OPTION_CFG, 8'h5A);
        rd(rst_seq_pkg::ADDR_OPTION_CFG, d);
        chk(d, 8'h5A);
        wr(3'h6, 8'hA5);
        rd(3'h6, d);
        chk(d, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_timing(input logic [1:0] m, input logic dn, input logic be,
        input logic brown, input int half, input int lo, input int hi);
        int n;
        logic [7:0] d;
        wr(rst_seq_pkg::ADDR_POWER_STATUS, 8'h03);
        wr(rst_seq_pkg::ADDR_OPTION_CFG, 8'h00);
        @(posedge clk);
        mode <= m;
        dly_n <= dn;
        bor_en <= be;
        i_model.osc_half = half;
        if (brown)
            i_model.brownout_recover();
        else
            i_model.supply_rise();
        wait_rel(n);
        chk_rng(n, lo, hi);
        chk(pc_load, 1'b1);
        chk(pc_value, 13'h0000);
        chk(status[7:3], 5'b00011);
        chk(opt, 8'hFF);
        rd(rst_seq_pkg::ADDR_POWER_STATUS, d);
        if (brown)
            chk(d, 8'h02);
        else
            chk(d[1], 1'b0);
        $display("test timing mode %0d done", m);
    endtask

    task automatic t_bor_off();
        @(posedge clk);
        bor_en <= 1'b0;
        i_model.brownout_recover();
        #1;
        chk(core_reset, 1'b0);
        $display("test brown-out disabled done");
    endtask

    task automatic t_ext_hold();
        int n;
        // The power-up delay runs out while the pin is still held low.
        @(posedge clk);
        dly_n <= 1'b0;
        i_model.set_pin(1'b0);
        i_model.supply_rise();
        repeat (PUC + 30) @(posedge clk);
        #1;
        chk(core_reset, 1'b1);
        i_model.set_pin(1'b1);
        wait_rel(n);
        chk_rng(n, 1, 1);
        $display("test pin hold done");
    endtask

    task automatic t_cause(input int k, input logic g, input logic [12:0] epc,
        input logic [7:0] est, input logic [7:0] eop);
        int n;
        wr(rst_seq_pkg::ADDR_CPU_STATUS, 8'hFF);
        wr(rst_seq_pkg::ADDR_OPTION_CFG, 8'h5A);
        wr(rst_seq_pkg::ADDR_PORT_DIR, 8'h5A);
        @(posedge clk);
        global_irq_enable <= g;
        pc <= 13'h0120 + 13'(k);
        sleeping <= (k == 1 || k == 2 || k == 5);
        wdt <= (k < 2);
        irq <= (k == 2);
        if (k >= 4)
            i_model.set_pin(1'b0);
        @(posedge clk);
        wdt <= 1'b0;
        irq <= 1'b0;
        sleeping <= 1'b0;
        if (k >= 4)
            i_model.set_pin(1'b1);
        wait_rel(n);
        chk_rng(n, 1, 1);
        chk(pc_load, 1'b1);
        chk(pc_value, epc);
        chk(status, est);
        chk(opt, eop);
        chk(pdir, eop);
        $display("test cause %0d done", k);
    endtask

    // A crystal-mode wake waits for the settle count before the core runs again.
    task automatic t_wake_settle();
        int n;
        wr(rst_seq_pkg::ADDR_OPTION_CFG, 8'h3C);
        @(posedge clk);
        mode <= 2'b01;
        pc <= 13'h0ABC;
        sleeping <= 1'b1;
        wdt <= 1'b1;
        @(posedge clk);
        sleeping <= 1'b0;
        wdt <= 1'b0;
        wait_rel(n);
        chk_rng(n, 2040, 2060);
        chk(pc_value, 13'h0ABD);
        chk(opt, 8'h3C);
        $display("test crystal wake done");
    endtask

    initial
    begin
        rst = 1'b1;
        wdt = 1'b0;
        irq = 1'b0;
        sleeping = 1'b0;
        global_irq_enable = 1'b0;
        pc = 13'h0123;
        mode = 2'b11;
        dly_n = 1'b1;
        bor_en = 1'b0;
        req = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_timing(2'b11, 1'b1, 1'b0, 1'b0, 1, 1, 2);
        t_timing(2'b11, 1'b0, 1'b0, 1'b0, 1, 18, 26);
        t_timing(2'b11, 1'b1, 1'b1, 1'b0, 1, 18, 26);
        t_timing(2'b00, 1'b1, 1'b0, 1'b0, 1, 2040, 2060);
        t_timing(2'b01, 1'b0, 1'b0, 1'b0, 1, 2060, 2090);
        t_timing(2'b10, 1'b1, 1'b0, 1'b0, 2, 4080, 4110);
        t_timing(2'b11, 1'b1, 1'b1, 1'b1, 1, 18, 26);
        t_bor_off();
        t_ext_hold();
        t_cause(0, 1'b0, 13'h0000, 8'h0F, 8'hFF);
        t_cause(1, 1'b0, 13'h0122, 8'hE7, 8'h5A);
        t_cause(2, 1'b1, 13'h0004, 8'hF7, 8'h5A);
        t_cause(2, 1'b0, 13'h0123, 8'hF7, 8'h5A);
        t_cause(4, 1'b0, 13'h0000, 8'h1F, 8'hFF);
        t_cause(5, 1'b0, 13'h0000, 8'h17, 8'hFF);
        t_wake_settle();
        conclude();
    end
endmodule // reset_timeout_sequencer_tb_top

bind reset_timeout_sequencer reset_timeout_sequencer_props #(.POWER_UP_CYCLES(POWER_UP_CYCLES))
    i_props (.core_clk_i, .rst_i, .power_on_event_i, .brownout_event_i, .ext_reset_n_i,
    .watchdog_timeout_i, .sleeping_i, .osc_mode_i, .power_up_delay_enable_n_i,
    .brownout_enable_i, .req_i, .core_reset_o, .pc_load_o, .cpu_status_o, .option_cfg_o,
    .port_dir_o);

`default_nettype wire
